// [core/ccpt_pkg.sv]
// shared constants and types for the capture/compare/pwm timer
package ccpt_pkg;
   localparam int STD_WIDTH = 16;
   localparam int WIDE_WIDTH = 32;
   localparam int NUM_CHAN = 4;
   localparam int DEAD_WIDTH = 8;
   localparam logic [1:0] MODE_CAPTURE = 2'h0;
   localparam logic [1:0] MODE_COMPARE = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_OFF = 2'h3;
   localparam logic CNT_RESET_VAL = 1'h0;
   typedef enum logic [2:0] {
      CCPT_DT_LOW = 3'h1,
      CCPT_DT_WAIT = 3'h2,
      CCPT_DT_HIGH = 3'h4
   } ccpt_dt_state_t;
endpackage

// [core/ccpt_dead_time.sv]
// dead-time insertion for one pwm channel, complementary outputs
`timescale 1ns/1ps
module ccpt_dead_time (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic [ccpt_pkg::DEAD_WIDTH-1:0] deadCycles,
   input wire logic pwmIn,
   // outputs
   output logic highOut,
   output logic lowOut
);
   ccpt_pkg::ccpt_dt_state_t state_q;
   logic [ccpt_pkg::DEAD_WIDTH-1:0] wait_q;
   logic target_q;

   // both outputs off while waiting, then the new side turns on
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= ccpt_pkg::CCPT_DT_LOW;
         wait_q <= '0;
         target_q <= 1'b0;
         highOut <= 1'b0;
         lowOut <= 1'b0;
      end else begin
         case (state_q)
            ccpt_pkg::CCPT_DT_LOW, ccpt_pkg::CCPT_DT_HIGH: begin
               highOut <= (state_q == ccpt_pkg::CCPT_DT_HIGH);
               lowOut <= (state_q == ccpt_pkg::CCPT_DT_LOW);
               if (pwmIn != (state_q == ccpt_pkg::CCPT_DT_HIGH)) begin
                  state_q <= ccpt_pkg::CCPT_DT_WAIT;
                  wait_q <= deadCycles;
                  target_q <= pwmIn;
                  highOut <= 1'b0;
                  lowOut <= 1'b0;
               end
            end
            ccpt_pkg::CCPT_DT_WAIT: begin
               highOut <= 1'b0;
               lowOut <= 1'b0;
               if (wait_q == '0) begin
                  state_q <= target_q ? ccpt_pkg::CCPT_DT_HIGH : ccpt_pkg::CCPT_DT_LOW;
               end else begin
                  wait_q <= wait_q - 1'b1;
               end
            end
            default: begin
               state_q <= ccpt_pkg::CCPT_DT_LOW;
            end
         endcase
      end
   end

   a_dead_gap: assert property (@(posedge clk) disable iff (!rst_b)
      !(highOut && lowOut)) else $error("both dead-time outputs high");
endmodule

// [core/ccpt_timer.sv]
// capture/compare/pwm timer, 16 or 32 bits, four channels
// How it works
// - standard instance uses a 16-bit counter
// - wide instance is identical but with a 32-bit counter
// - up to four channels, each able to capture or compare
// - each channel independently set to capture, compare or pwm
// - capture mode copies counter into channel buffer on selected event
// - compare mode output follows counter compared with threshold
// - pwm waveform set by compare values written over time
// - dead-time insertion only on instance zero of each kind
// - counter counts clock cycles or selected external events
// - timed trigger pulses go out on the reflex event network
`timescale 1ns/1ps
module ccpt_timer #(
   parameter bit WIDE = 1'b0,
   parameter int INSTANCE = 0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // counter control
   input wire logic countEnable,
   input wire logic eventCountMode,
   input wire logic countEventPin,
   // channel control
   input wire logic [2*ccpt_pkg::NUM_CHAN-1:0] chanMode,
   input wire logic [ccpt_pkg::NUM_CHAN-1:0] captureEventPin,
   input wire logic [ccpt_pkg::NUM_CHAN*ccpt_pkg::WIDE_WIDTH-1:0] compareValue,
   input wire logic [ccpt_pkg::NUM_CHAN-1:0] compareWrite,
   input wire logic [ccpt_pkg::DEAD_WIDTH-1:0] deadCycles,
   input wire logic deadEnable,
   // status
   input wire logic [ccpt_pkg::NUM_CHAN-1:0] flagClear,
   output logic [ccpt_pkg::NUM_CHAN-1:0] chanFlag,
   output logic [ccpt_pkg::NUM_CHAN*ccpt_pkg::WIDE_WIDTH-1:0] captureValue,
   output logic [ccpt_pkg::WIDE_WIDTH-1:0] counterValue,
   // pins
   output logic [ccpt_pkg::NUM_CHAN-1:0] chanOut,
   output logic [ccpt_pkg::NUM_CHAN-1:0] chanOutCompl,
   // reflex event network
   output logic [ccpt_pkg::NUM_CHAN-1:0] reflexChanTrig,
   output logic reflexWrapTrig
);
   localparam int W = WIDE ? ccpt_pkg::WIDE_WIDTH : ccpt_pkg::STD_WIDTH;
   localparam int N = ccpt_pkg::NUM_CHAN;
   localparam bit HAS_DEAD = (INSTANCE == 0);

   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   logic cntSync1_q, cntSync2_q, cntSync3_q;
   logic [N-1:0] capSync1_q, capSync2_q, capSync3_q;
   logic tick;
   logic wrap;
   logic [N-1:0] capEvent;
   logic [N-1:0] cmpEvent;
   logic [N-1:0] rawOut;
   logic [N*W-1:0] thresh_q;
   logic [N*W-1:0] active_q;

   function automatic logic [1:0] chanModeOf(input logic [2*N-1:0] m, input int i);
      chanModeOf = m[2*i +: 2];
   endfunction

   // pin synchronisers, third stage for edge detection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cntSync1_q <= 1'b0;
         cntSync2_q <= 1'b0;
         cntSync3_q <= 1'b0;
         capSync1_q <= '0;
         capSync2_q <= '0;
         capSync3_q <= '0;
      end else begin
         cntSync1_q <= countEventPin;
         cntSync2_q <= cntSync1_q;
         cntSync3_q <= cntSync2_q;
         capSync1_q <= captureEventPin;
         capSync2_q <= capSync1_q;
         capSync3_q <= capSync2_q;
      end
   end

   assign tick = countEnable && (eventCountMode ? (cntSync2_q && !cntSync3_q) : 1'b1);
   assign wrap = tick && (count_q == {W{1'b1}});
   assign count_d = tick ? count_q + 1'b1 : count_q;

   // counter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // compare shadow: in pwm mode a new value takes effect at wrap for glitch-free pwm, in other modes two cycles after the write
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         thresh_q <= '0;
         active_q <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (compareWrite[i]) begin
               thresh_q[i*W +: W] <= compareValue[i*ccpt_pkg::WIDE_WIDTH +: W];
            end
            if (wrap || chanModeOf(chanMode, i) != ccpt_pkg::MODE_PWM) begin
               active_q[i*W +: W] <= thresh_q[i*W +: W];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < N; i++) begin
         capEvent[i] = (chanModeOf(chanMode, i) == ccpt_pkg::MODE_CAPTURE)
            && capSync2_q[i] && !capSync3_q[i];
         cmpEvent[i] = (chanModeOf(chanMode, i) == ccpt_pkg::MODE_COMPARE
            || chanModeOf(chanMode, i) == ccpt_pkg::MODE_PWM)
            && tick && (count_q == active_q[i*W +: W]);
         rawOut[i] = (chanModeOf(chanMode, i) == ccpt_pkg::MODE_COMPARE
            || chanModeOf(chanMode, i) == ccpt_pkg::MODE_PWM)
            && (count_q < active_q[i*W +: W]);
      end
   end

   // capture buffers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         captureValue <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (capEvent[i]) begin
               captureValue[i*ccpt_pkg::WIDE_WIDTH +: ccpt_pkg::WIDE_WIDTH] <=
                  ccpt_pkg::WIDE_WIDTH'(count_q);
            end
         end
      end
   end

   // sticky flags, set wins over clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         chanFlag <= '0;
      end else begin
         chanFlag <= (chanFlag & ~flagClear) | capEvent | cmpEvent;
      end
   end

   // reflex triggers and counter view
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reflexChanTrig <= '0;
         reflexWrapTrig <= 1'b0;
         counterValue <= '0;
      end else begin
         reflexChanTrig <= capEvent | cmpEvent;
         reflexWrapTrig <= wrap;
         counterValue <= ccpt_pkg::WIDE_WIDTH'(count_d);
      end
   end

   // channel outputs, dead time only on instance zero
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gChan
         if (HAS_DEAD) begin : gDead
            logic dtHigh, dtLow;
            ccpt_dead_time uDead (
               .clk(clk),
               .rst_b(rst_b),
               .deadCycles(deadCycles),
               .pwmIn(rawOut[g]),
               .highOut(dtHigh),
               .lowOut(dtLow)
            );
            always_ff @(posedge clk) begin
               if (!rst_b) begin
                  chanOut[g] <= 1'b0;
                  chanOutCompl[g] <= 1'b0;
               end else if (deadEnable
                  && chanModeOf(chanMode, g) == ccpt_pkg::MODE_PWM) begin
                  chanOut[g] <= dtHigh;
                  chanOutCompl[g] <= dtLow;
               end else begin
                  chanOut[g] <= rawOut[g];
                  chanOutCompl[g] <= !rawOut[g];
               end
            end
         end else begin : gPlain
            always_ff @(posedge clk) begin
               if (!rst_b) begin
                  chanOut[g] <= 1'b0;
                  chanOutCompl[g] <= 1'b0;
               end else begin
                  chanOut[g] <= rawOut[g];
                  chanOutCompl[g] <= !rawOut[g];
               end
            end
         end
      end
   endgenerate

   // checks
   a_count_wraps: assert property (@(posedge clk) disable iff (!rst_b)
      wrap |=> (count_q == '0) && reflexWrapTrig) else $error("counter did not wrap");
   a_count_holds: assert property (@(posedge clk) disable iff (!rst_b)
      !countEnable |=> $stable(count_q)) else $error("counter moved while disabled");
   a_count_steps: assert property (@(posedge clk) disable iff (!rst_b)
      tick && !wrap |=> count_q == $past(count_q) + 1'b1) else $error("counter step");
   a_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
      (capEvent | cmpEvent) != '0 |=> (chanFlag & $past(capEvent | cmpEvent))
      == $past(capEvent | cmpEvent)) else $error("flag not set");
   a_flag_clears: assert property (@(posedge clk) disable iff (!rst_b)
      flagClear[0] && !capEvent[0] && !cmpEvent[0] |=> !chanFlag[0])
      else $error("flag not cleared");
   a_capture_value: assert property (@(posedge clk) disable iff (!rst_b)
      capEvent[1] |=> captureValue[ccpt_pkg::WIDE_WIDTH +: W] == $past(count_q))
      else $error("capture value");
   a_compare_out: assert property (@(posedge clk) disable iff (!rst_b)
      chanModeOf(chanMode, 0) == ccpt_pkg::MODE_COMPARE
      |=> chanOut[0] == ($past(count_q) < $past(active_q[W-1:0])))
      else $error("compare output");
   a_trig_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      cmpEvent[0] |=> reflexChanTrig[0]) else $error("trigger missing");
   a_capture_mode: assert property (@(posedge clk) disable iff (!rst_b)
      chanModeOf(chanMode, 2) != ccpt_pkg::MODE_CAPTURE
      |=> $stable(captureValue[2*ccpt_pkg::WIDE_WIDTH +: ccpt_pkg::WIDE_WIDTH]))
      else $error("capture outside mode");
endmodule

// [bench/ccpt_trig_sink.sv]
// model of the peripherals that count the timer's reflex triggers
`timescale 1ns/1ps
module ccpt_trig_sink (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // reflex event network
   input wire logic [ccpt_pkg::NUM_CHAN-1:0] chanTrig,
   input wire logic wrapTrig,
   // counts seen
   output int chanCount,
   output int wrapCount
);
   // consumers act on every clock with a trigger present
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         chanCount <= 0;
         wrapCount <= 0;
      end else begin
         chanCount <= chanCount + ((chanTrig !== 4'h0) ? 1 : 0);
         wrapCount <= wrapCount + ((wrapTrig === 1'b1) ? 1 : 0);
      end
   end
endmodule

// [bench/capture_compare_pwm_timer_bench.sv]
// self-checking bench for the 16-bit timer instance
`timescale 1ns/1ps
module capture_compare_pwm_timer_bench;
   logic clk, rst_b, countEnable, eventCountMode, countEventPin, deadEnable;
   logic [7:0] chanMode, deadCycles, seed;
   logic [3:0] captureEventPin, compareWrite, flagClear;
   logic [3:0] chanFlag, chanOut, chanOutCompl, reflexChanTrig;
   logic [127:0] compareValue, captureValue;
   logic [31:0] counterValue, c0, thr;
   logic reflexWrapTrig;
   int chanCount, wrapCount, nMismatch, nCompared, k, n, nHi, nGap, nBoth;

   ccpt_timer #(.WIDE(1'b0), .INSTANCE(0)) dut (.clk(clk), .rst_b(rst_b),
      .countEnable(countEnable), .eventCountMode(eventCountMode),
      .countEventPin(countEventPin), .chanMode(chanMode),
      .captureEventPin(captureEventPin), .compareValue(compareValue),
      .compareWrite(compareWrite), .deadCycles(deadCycles), .deadEnable(deadEnable),
      .flagClear(flagClear), .chanFlag(chanFlag), .captureValue(captureValue),
      .counterValue(counterValue), .chanOut(chanOut), .chanOutCompl(chanOutCompl),
      .reflexChanTrig(reflexChanTrig), .reflexWrapTrig(reflexWrapTrig));
   ccpt_trig_sink sink (.clk(clk), .rst_b(rst_b), .chanTrig(reflexChanTrig),
      .wrapTrig(reflexWrapTrig), .chanCount(chanCount), .wrapCount(wrapCount));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // high time of one pwm pulse after the leading dead gap is taken out
   function automatic int hiCycles(input int thr3, input int d);
      return thr3 - d - 2;
   endfunction

   task automatic step(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic chk(input bit ok, input string msg);
      nCompared++;
      if (!ok) begin
         nMismatch++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic waitFlag(input int ch, input int lim);
      for (k = 0; k < lim && chanFlag[ch] !== 1'b1; k++) step(1);
      if (chanFlag[ch] !== 1'b1) begin
         chk(0, "flag wait ran out");
         summarize();
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatched %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      countEnable = 1'b1;
      eventCountMode = 1'b0;
      countEventPin = 1'b0;
      chanMode = 8'hF3;
      captureEventPin = 4'h0;
      compareValue = '0;
      compareWrite = 4'h0;
      deadCycles = 8'h03;
      deadEnable = 1'b0;
      flagClear = 4'h0;
      seed = 8'h47;
      nMismatch = 0;
      nCompared = 0;
      step(2);
      chk(counterValue === 32'h0 && chanFlag === 4'h0 && chanOut === 4'h0, "reset");
      chk(chanOutCompl === 4'h0, "reset compl");
      rst_b = 1'b1;
      step(3);
      c0 = counterValue;
      seed = lfsr(seed);
      step(8 + seed[3:0]);
      chk(counterValue - c0 === 32'(8 + seed[3:0]), "time count");
      // counter frozen while disabled
      countEnable = 1'b0;
      c0 = counterValue;
      step(4 + seed[6:4]);
      chk(counterValue === c0, "count hold");
      countEnable = 1'b1;
      $display("count test done");
      // compare channel 0 against a random threshold ahead of the count
      seed = lfsr(seed);
      thr = (counterValue + 32'h14 + 32'(seed[4:0])) & 32'h0000FFFF;
      compareValue[31:0] = thr;
      compareWrite = 4'h1;
      chanMode = 8'hF1;
      step(1);
      compareWrite = 4'h0;
      n = chanCount;
      step(3);
      chk(chanOut[0] === 1'b1 && chanOutCompl[0] === 1'b0, "below threshold");
      chk(chanFlag[0] === 1'b0, "early flag");
      waitFlag(0, 80);
      step(2);
      chk(chanOut[0] === 1'b0 && chanOutCompl[0] === 1'b1, "at threshold");
      chk(chanCount - n === 1, "one trigger");
      flagClear = 4'h1;
      step(1);
      flagClear = 4'h0;
      step(1);
      chk(chanFlag[0] === 1'b0, "flag clear");
      $display("compare test done");
      // capture on channel 1, refused on channel 2 which is off
      c0 = counterValue;
      captureEventPin = 4'h6;
      step(3);
      captureEventPin = 4'h0;
      waitFlag(1, 10);
      chk(captureValue[63:32] === c0 + 32'h2, "capture");
      chk(chanFlag[2] === 1'b0, "capture refused");
      $display("capture test done");
      // external event counting with a random number of pulses
      eventCountMode = 1'b1;
      step(4);
      c0 = counterValue;
      seed = lfsr(seed);
      n = 3 + seed[2:0];
      repeat (n) begin
         countEventPin = 1'b1;
         step(4);
         countEventPin = 1'b0;
         step(4);
      end
      chk(counterValue - c0 === 32'(n), "event count");
      $display("event test done");
      // pwm with dead time on channel 3, threshold takes hold at the wrap
      eventCountMode = 1'b0;
      seed = lfsr(seed);
      deadCycles = {5'h0, seed[2:0]};
      deadEnable = 1'b1;
      chanMode = 8'hB1;
      thr = 32'h20;
      compareValue[127:96] = thr;
      compareWrite = 4'h8;
      step(1);
      compareWrite = 4'h0;
      n = wrapCount;
      for (k = 0; k < 70000 && wrapCount == n; k++) step(1);
      chk(wrapCount - n === 1, "wrap trigger");
      chk(counterValue === 32'h1, "wrap to zero");
      nHi = 0;
      nGap = 0;
      nBoth = 0;
      repeat (64) begin
         step(1);
         if (chanOut[3] === 1'b1) nHi++;
         if (chanOut[3] === 1'b0 && chanOutCompl[3] === 1'b0) nGap++;
         if (chanOut[3] !== 1'b0 && chanOutCompl[3] !== 1'b0) nBoth++;
      end
      chk(nHi == hiCycles(thr, deadCycles), "pwm high time");
      chk(nGap == 2 * (deadCycles + 2), "dead gaps");
      chk(nBoth == 0, "both sides on");
      $display("pwm and wrap test done");
      summarize();
   end
endmodule
